//--- core/scd_pkg.sv
// Package of shared constants and types for the sample clock delay and mark block.
package scd_pkg;

   // Widths of samples and delay settings.
   localparam int SAMPLE_W = 12;
   localparam int NARROW_W = 8;
   localparam int DELAY_W = 8;

   // Ramp timing: one ramp interval is 256 device clock cycles.
   localparam int RAMP_INTERVAL = 256;
   localparam logic [7:0] RAMP_LAST = 8'hFF;
   localparam logic [7:0] RAMP_STEP_SLOW = 8'h01;
   localparam logic [7:0] RAMP_STEP_FAST = 8'h04;

   // Pipeline latency of the converter core, in device clock cycles.
   localparam int CORE_LATENCY = 4;

   // Reset values of the delay controls.
   localparam logic [7:0] COARSE_RESET = 8'h00;
   localparam logic [7:0] FINE_RESET = 8'h00;

   // Sampling mode of the converter.
   typedef enum logic {
      SCD_DUAL,
      SCD_SINGLE
   } scd_mode_t;

endpackage : scd_pkg

//--- core/scd_if.sv
// Interface joining the converter end and the controlling receiver end.
`timescale 1ns/1ps
interface scd_if;
   import scd_pkg::*;

   // Control from the controller to the converter.
   logic mark_enable;
   logic narrow_format;
   logic decimation_mode;
   scd_mode_t mode;
   logic half_period_clock_invert;
   logic [7:0] coarse_delay_setting;
   logic coarse_write;
   logic [7:0] fine_delay_setting;
   logic delay_ramp_enable;
   logic delay_ramp_speed;
   logic sysref;
   // Data and status from the converter.
   logic [11:0] sample_rise;
   logic [11:0] sample_fall;
   logic sample_valid;
   logic fall_valid;
   logic [7:0] coarse_effective;
   logic ramp_busy;
   logic sysref_captured;

   modport device (
      input mark_enable, narrow_format, decimation_mode, mode, half_period_clock_invert,
      input coarse_delay_setting, coarse_write, fine_delay_setting, delay_ramp_enable,
      input delay_ramp_speed, sysref,
      output sample_rise, sample_fall, sample_valid, fall_valid, coarse_effective,
      output ramp_busy, sysref_captured
   );
   modport host (
      output mark_enable, narrow_format, decimation_mode, mode, half_period_clock_invert,
      output coarse_delay_setting, coarse_write, fine_delay_setting, delay_ramp_enable,
      output delay_ramp_speed, sysref,
      input sample_rise, sample_fall, sample_valid, fall_valid, coarse_effective,
      input ramp_busy, sysref_captured
   );
endinterface : scd_if

//--- core/scd_device.sv
// Converter end: trigger mark insertion, edge choice, aperture delay and ramp.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// [RULE_01] Mark enabled: eleven upper bits plus mark.
// [RULE_02] Mark path latency equals converter core latency.
// [RULE_03] Eight-bit formats put mark in LSB.
// [RULE_04] Controller never marks with decimation modes.
// [RULE_05] Asynchronous mark sampled with analog input.
// [RULE_06] Dual mode samples each rising edge.
// [RULE_07] Single mode samples both clock edges.
// [RULE_08] Device clock drives processing and serializer.
// [RULE_09] SYSREF pulse or periodic, captured correctly.
// [RULE_10] Periodic SYSREF obeys multiframe frequency formula.
// [RULE_11] Invert control delays sampling half period.
// [RULE_12] Coarse and fine each have 256 settings.
// [RULE_13] Invert, coarse, fine delays are independent, additive.
// [RULE_14] Aperture delay shifts every internal clock.
// [RULE_15] Delay rewrites allowed live; use ramp.
// [RULE_16] Ramp steps one or four per 256.
// [RULE_17] Each coarse write with ramp restarts ramp.
// [RULE_18] SYSREF captured on deterministic clock edge.
// [RULE_19] Ramp off: coarse write applies directly.
// [RULE_20] Ramp speed bit: zero slow, one fast.
module scd_device
   import scd_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic TRIGGER_MARK_INPUT,
   input wire logic [11:0] CORE_RISE,
   input wire logic [11:0] CORE_FALL,
   output logic [7:0] APERTURE_DELAY_COARSE,
   output logic [7:0] APERTURE_DELAY_FINE,
   output logic APERTURE_DELAY_INVERT,
   scd_if.device LINK
);

   //////////////////////////////////////////////////////////////////////////
   // Trigger mark path.

   logic [CORE_LATENCY-1:0] mark_pipe;
   logic [7:0] coarse_target;
   logic [7:0] coarse_now;
   logic [7:0] ramp_count;
   logic ramp_active;
   logic sysref_meta;
   logic sysref_sync;
   logic sysref_prev;
   logic [7:0] ramp_step;

   // Shapes one sample: mark replaces the LSB of the 12-bit or 8-bit word.
   function automatic logic [11:0] scd_mark(input logic [11:0] raw, input logic mk,
                                            input logic en, input logic narrow);
      logic [11:0] res;
      res = raw;
      if (en && narrow) begin
         res = {4'h0, raw[11:5], mk};
      end else if (en) begin
         res = {raw[11:1], mk};
      end else if (narrow) begin
         res = {4'h0, raw[11:4]};
      end
      return res;
   endfunction : scd_mark

   // Picks the coarse step of one ramp interval from the speed bit.
   // One helper keeps the rising and the falling ramp branches in step.
   function automatic logic [7:0] scd_ramp_step(input logic fast);
      logic [7:0] step;
      step = RAMP_STEP_SLOW;
      if (fast) begin
         step = RAMP_STEP_FAST;
      end
      return step;
   endfunction : scd_ramp_step

   // The pipe is as long as the core latency, so a mark taken together with
   // an analog sample leaves the block in the same output word as that sample.
   // [RULE_05] asynchronous mark capture
   // [RULE_02] matched latency pipeline
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         mark_pipe <= '0;
      end else begin
         mark_pipe <= {mark_pipe[CORE_LATENCY-2:0], TRIGGER_MARK_INPUT};
      end
   end

   // [RULE_01] mark into LSB
   // [RULE_03] narrow format LSB
   // [RULE_06] rising edge sample
   // [RULE_07] falling edge sample
   // [RULE_08] device clock drives output
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         LINK.sample_rise <= 12'h000;
         LINK.sample_fall <= 12'h000;
         LINK.sample_valid <= 1'b0;
         LINK.fall_valid <= 1'b0;
      end else begin
         LINK.sample_rise <= scd_mark(CORE_RISE, mark_pipe[CORE_LATENCY-1],
                                      LINK.mark_enable, LINK.narrow_format);
         LINK.sample_fall <= scd_mark(CORE_FALL, mark_pipe[CORE_LATENCY-1],
                                      LINK.mark_enable, LINK.narrow_format);
         LINK.sample_valid <= 1'b1;
         LINK.fall_valid <= (LINK.mode == SCD_SINGLE);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Aperture delay and coarse ramp.

   // Captures each coarse write as the ramp target.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         coarse_target <= COARSE_RESET;
      end else if (LINK.coarse_write) begin
         coarse_target <= LINK.coarse_delay_setting;
      end
   end

   // Counts 256-cycle ramp intervals; a new ramp restarts the interval.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         ramp_count <= 8'h00;
      end else if (LINK.coarse_write) begin
         ramp_count <= 8'h00;
      end else begin
         ramp_count <= ramp_count + 8'h01;
      end
   end

   // Step size of the running ramp, taken from the current speed bit.
   assign ramp_step = scd_ramp_step(LINK.delay_ramp_speed);

   // Moves the effective coarse value toward the target.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         coarse_now <= COARSE_RESET;
         ramp_active <= 1'b0;
      end else if (LINK.coarse_write) begin
         // [RULE_17] write restarts ramp
         // [RULE_19] direct load without ramp
         ramp_active <= LINK.delay_ramp_enable;
         if (!LINK.delay_ramp_enable) begin
            coarse_now <= LINK.coarse_delay_setting;
         end
      end else if (ramp_active && ramp_count == RAMP_LAST) begin
         // [RULE_16] gradual step per interval
         // [RULE_20] speed bit selects step
         // The last step is clamped so the ramp never overshoots the target.
         if (coarse_now < coarse_target) begin
            if (8'(coarse_target - coarse_now) <= ramp_step) begin
               coarse_now <= coarse_target;
               ramp_active <= 1'b0;
            end else begin
               coarse_now <= 8'(coarse_now + ramp_step);
            end
         end else if (coarse_now > coarse_target) begin
            if (8'(coarse_now - coarse_target) <= ramp_step) begin
               coarse_now <= coarse_target;
               ramp_active <= 1'b0;
            end else begin
               coarse_now <= 8'(coarse_now - ramp_step);
            end
         end else begin
            ramp_active <= 1'b0;
         end
      end
   end

   // [RULE_11] half period invert
   // [RULE_12] 256 coarse and fine
   // [RULE_13] independent additive controls
   // [RULE_14] delay shifts all clocks
   // [RULE_15] live rewrite accepted
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         APERTURE_DELAY_COARSE <= COARSE_RESET;
         APERTURE_DELAY_FINE <= FINE_RESET;
         APERTURE_DELAY_INVERT <= 1'b0;
         LINK.coarse_effective <= COARSE_RESET;
         LINK.ramp_busy <= 1'b0;
      end else begin
         APERTURE_DELAY_COARSE <= coarse_now;
         APERTURE_DELAY_FINE <= LINK.fine_delay_setting;
         APERTURE_DELAY_INVERT <= LINK.half_period_clock_invert;
         LINK.coarse_effective <= coarse_now;
         LINK.ramp_busy <= ramp_active;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // SYSREF capture.

   // Two flops settle the incoming reference; the edge detector reads the second one
   // and its one-cycle delayed copy, so a metastable first stage never reaches the capture pulse.
   // [RULE_18] deterministic edge capture
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         sysref_meta <= 1'b0;
         sysref_sync <= 1'b0;
         sysref_prev <= 1'b0;
         LINK.sysref_captured <= 1'b0;
      end else begin
         sysref_meta <= LINK.sysref;
         sysref_sync <= sysref_meta;
         sysref_prev <= sysref_sync;
         LINK.sysref_captured <= sysref_sync && !sysref_prev;
      end
   end

endmodule : scd_device

//--- core/scd_host.sv
// Controller end: drives delay and mark settings, issues SYSREF, takes samples.
`timescale 1ns/1ps
module scd_host
   import scd_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic MARK_ENABLE,
   input wire logic NARROW_FORMAT,
   input wire logic DECIMATION_MODE,
   input wire logic SINGLE_MODE,
   input wire logic CLOCK_INVERT,
   input wire logic [7:0] COARSE_VALUE,
   input wire logic COARSE_WRITE,
   input wire logic [7:0] FINE_VALUE,
   input wire logic RAMP_ENABLE,
   input wire logic RAMP_FAST,
   input wire logic SYSREF_REQUEST,
   output logic [11:0] SAMPLE_RISE,
   output logic [11:0] SAMPLE_FALL,
   output logic SAMPLE_VALID,
   output logic FALL_VALID,
   output logic RAMP_BUSY,
   output logic SYSREF_SEEN,
   scd_if.host LINK
);

   //////////////////////////////////////////////////////////////////////////
   // Control toward the converter.

   // [RULE_04] no mark under decimation
   // [RULE_15] ramp on live rewrite
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         LINK.mark_enable <= 1'b0;
         LINK.narrow_format <= 1'b0;
         LINK.decimation_mode <= 1'b0;
         LINK.mode <= SCD_DUAL;
         LINK.half_period_clock_invert <= 1'b0;
         LINK.coarse_delay_setting <= COARSE_RESET;
         LINK.coarse_write <= 1'b0;
         LINK.fine_delay_setting <= FINE_RESET;
         LINK.delay_ramp_enable <= 1'b0;
         LINK.delay_ramp_speed <= 1'b0;
      end else begin
         LINK.mark_enable <= MARK_ENABLE && !DECIMATION_MODE;
         LINK.narrow_format <= NARROW_FORMAT;
         LINK.decimation_mode <= DECIMATION_MODE;
         LINK.mode <= SINGLE_MODE ? SCD_SINGLE : SCD_DUAL;
         LINK.half_period_clock_invert <= CLOCK_INVERT;
         LINK.coarse_delay_setting <= COARSE_VALUE;
         LINK.coarse_write <= COARSE_WRITE;
         LINK.fine_delay_setting <= FINE_VALUE;
         LINK.delay_ramp_enable <= RAMP_ENABLE;
         LINK.delay_ramp_speed <= RAMP_FAST;
      end
   end

   // [RULE_09] pulse or periodic SYSREF
   // [RULE_10] caller sets periodic rate
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         LINK.sysref <= 1'b0;
      end else begin
         LINK.sysref <= SYSREF_REQUEST;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Data and status from the converter.

   // Registers the returned samples and status.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         SAMPLE_RISE <= 12'h000;
         SAMPLE_FALL <= 12'h000;
         SAMPLE_VALID <= 1'b0;
         FALL_VALID <= 1'b0;
         RAMP_BUSY <= 1'b0;
         SYSREF_SEEN <= 1'b0;
      end else begin
         SAMPLE_RISE <= LINK.sample_rise;
         SAMPLE_FALL <= LINK.sample_fall;
         SAMPLE_VALID <= LINK.sample_valid;
         FALL_VALID <= LINK.fall_valid;
         RAMP_BUSY <= LINK.ramp_busy;
         SYSREF_SEEN <= LINK.sysref_captured;
      end
   end

endmodule : scd_host

//--- test/scd_monitor.sv
// Checker of the link between the converter end and the controller end.
`timescale 1ns/1ps
module scd_monitor
   import scd_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic mark_enable,
   input wire logic narrow_format,
   input wire logic decimation_mode,
   input wire scd_mode_t mode,
   input wire logic [7:0] coarse_delay_setting,
   input wire logic coarse_write,
   input wire logic delay_ramp_enable,
   input wire logic delay_ramp_speed,
   input wire logic sysref,
   input wire logic [11:0] sample_rise,
   input wire logic sample_valid,
   input wire logic fall_valid,
   input wire logic [7:0] coarse_effective,
   input wire logic ramp_busy,
   input wire logic sysref_captured
);
   ////////////////////////////////////////////////////////////////////////////////
   // All checks share the device clock and the link reset.
   default clocking mon_clk @(posedge CLK_SYS);
   endclocking
   default disable iff (!ARST_N);

   direct_coarse_a: assert property (coarse_write && !delay_ramp_enable |-> ##2
      coarse_effective == $past(coarse_delay_setting, 2)) else $error("Coarse write was not applied directly.");
   ramp_start_a: assert property (coarse_write && delay_ramp_enable |-> ##2 ramp_busy)
      else $error("Ramp did not start after a coarse write.");
   ramp_step_a: assert property ($changed(coarse_effective) && $past(delay_ramp_enable, 2) &&
      !$past(coarse_write, 2) |-> (8'(coarse_effective - $past(coarse_effective)) <=
      ($past(delay_ramp_speed) ? RAMP_STEP_FAST : RAMP_STEP_SLOW)
      || 8'(($past(coarse_effective) - coarse_effective)) <=
      ($past(delay_ramp_speed) ? RAMP_STEP_FAST : RAMP_STEP_SLOW)))
      else $error("Ramp step too large.");
   ramp_end_a: assert property ($fell(ramp_busy) |-> coarse_effective == coarse_delay_setting)
      else $error("Ramp ended away from the written value.");
   sysref_edge_a: assert property ($rose(sysref) |-> ##[2:3] sysref_captured)
      else $error("Sysref capture late.");
   sysref_pulse_a: assert property (sysref_captured |=> !sysref_captured)
      else $error("Sysref capture pulse too long.");
   sample_flow_a: assert property ($past(ARST_N) |-> sample_valid)
      else $error("Samples stopped after reset.");
   fall_single_a: assert property ((mode == SCD_SINGLE) [*3] |-> fall_valid)
      else $error("Falling samples missing in single mode.");
   fall_dual_a: assert property ((mode == SCD_DUAL) [*3] |-> !fall_valid)
      else $error("Falling samples seen in dual mode.");
   narrow_width_a: assert property (narrow_format [*3] |-> sample_rise[11:8] == 4'h0)
      else $error("Narrow sample wider than eight bits.");
   mark_decim_a: assert property (!(mark_enable && decimation_mode))
      else $error("Mark enabled in a decimation mode.");
endmodule : scd_monitor

//--- test/sample_clock_delay_and_mark_bench.sv
// Testbench joining the converter end and the controller end through the link.
`timescale 1ns/1ps
module sample_clock_delay_and_mark_bench;
   import scd_pkg::*;
   logic clk_sys, arst_n, mark_in, mark_en, narrow, decim, single, inv, cwr, ramp_en, ramp_fast, sysref_req;
   logic [11:0] core_rise, core_fall, s_rise, s_fall;
   logic [7:0] coarse_v, fine_v, a_coarse, a_fine;
   logic s_valid, f_valid, busy, seen, a_inv;
   int miscompares, checked, cycles;

   scd_if u_link();
   scd_device i_scd_device(.CLK_SYS(clk_sys), .ARST_N(arst_n), .TRIGGER_MARK_INPUT(mark_in), .CORE_RISE(core_rise),
      .CORE_FALL(core_fall), .APERTURE_DELAY_COARSE(a_coarse), .APERTURE_DELAY_FINE(a_fine),
      .APERTURE_DELAY_INVERT(a_inv), .LINK(u_link));
   scd_host i_scd_host(.CLK_SYS(clk_sys), .ARST_N(arst_n), .MARK_ENABLE(mark_en), .NARROW_FORMAT(narrow),
      .DECIMATION_MODE(decim), .SINGLE_MODE(single), .CLOCK_INVERT(inv), .COARSE_VALUE(coarse_v), .COARSE_WRITE(cwr),
      .FINE_VALUE(fine_v), .RAMP_ENABLE(ramp_en), .RAMP_FAST(ramp_fast), .SYSREF_REQUEST(sysref_req),
      .SAMPLE_RISE(s_rise), .SAMPLE_FALL(s_fall), .SAMPLE_VALID(s_valid), .FALL_VALID(f_valid), .RAMP_BUSY(busy),
      .SYSREF_SEEN(seen), .LINK(u_link));
   scd_monitor u_mon(.CLK_SYS(clk_sys), .ARST_N(arst_n), .mark_enable(u_link.mark_enable),
      .narrow_format(u_link.narrow_format), .decimation_mode(u_link.decimation_mode), .mode(u_link.mode),
      .coarse_delay_setting(u_link.coarse_delay_setting), .coarse_write(u_link.coarse_write),
      .delay_ramp_enable(u_link.delay_ramp_enable), .delay_ramp_speed(u_link.delay_ramp_speed),
      .sysref(u_link.sysref), .sample_rise(u_link.sample_rise), .sample_valid(u_link.sample_valid),
      .fall_valid(u_link.fall_valid), .coarse_effective(u_link.coarse_effective), .ramp_busy(u_link.ramp_busy),
      .sysref_captured(u_link.sysref_captured));

   ////////////////////////////////////////////////////////////////////////////////
   // Device clock of 4 ns period.
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // Hang guard; the whole sequence needs about 2250 cycles.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 10000) begin
         miscompares++;
         stop_test();
      end
   end

   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test

   // Inputs always change one nanosecond after a rising edge.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One mark pulse; it reaches the bench five edges after the edge that takes it:
   // three more pipe stages, then the device and host output registers.
   task automatic mark_run(input logic en, input logic nar, input logic dec);
      logic [11:0] exp;
      logic hit;
      logic m;
      m = en && !dec;
      mark_en = en;
      narrow = nar;
      decim = dec;
      tick(6);
      mark_in = 1'b1;
      tick(1);
      mark_in = 1'b0;
      for (int k = 1; k <= 9; k++) begin
         tick(1);
         hit = m && k == CORE_LATENCY + 1;
         if (nar) exp = m ? {4'h0, core_rise[11:5], hit} : {4'h0, core_rise[11:4]};
         else exp = m ? {core_rise[11:1], hit} : core_rise;
         chk(s_rise, exp);
      end
   endtask : mark_run

   task automatic wr(input logic [7:0] v);
      coarse_v = v;
      cwr = 1'b1;
      tick(1);
      cwr = 1'b0;
   endtask : wr

   // A ramp of k intervals must finish at the target within a few cycles of k times 256.
   task automatic ramp(input logic f, input logic [7:0] t, input int k);
      int n;
      ramp_fast = f;
      wr(t);
      tick(6);
      n = 6;
      while (busy === 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      chk({4'h0, a_coarse}, {4'h0, t});
      chk({11'h0, n >= k * RAMP_INTERVAL - 4 && n <= k * RAMP_INTERVAL + 8}, 12'h001);
   endtask : ramp

   initial begin
      {mark_in, mark_en, narrow, decim, single, inv, cwr, ramp_en, ramp_fast, sysref_req} = '0;
      {coarse_v, fine_v} = '0;
      core_rise = 12'hA5B;
      core_fall = 12'h3C6;
      arst_n = 1'b0;
      repeat (8) @(posedge clk_sys);
      #1 arst_n = 1'b1;
      tick(3);
      chk({4'h0, a_coarse}, {4'h0, COARSE_RESET});
      chk({4'h0, a_fine}, {4'h0, FINE_RESET});
      chk({11'h0, s_valid}, 12'h001);
      mark_run(1'b1, 1'b0, 1'b0);
      mark_run(1'b1, 1'b1, 1'b0);
      mark_run(1'b0, 1'b0, 1'b0);
      mark_run(1'b1, 1'b0, 1'b1);
      mark_run(1'b0, 1'b1, 1'b0);
      narrow = 1'b0;
      single = 1'b1;
      tick(4);
      chk({11'h0, f_valid}, 12'h001);
      chk(s_fall, core_fall);
      single = 1'b0;
      tick(4);
      chk({11'h0, f_valid}, 12'h000);
      for (int i = 0; i < 3; i++) begin
         fine_v = 8'h81 >> (i * 4);
         inv = ~inv;
         tick(3);
         chk({4'h0, a_fine}, {4'h0, fine_v});
         chk({11'h0, a_inv}, {11'h0, inv});
      end
      wr(8'hFF);
      tick(4);
      chk({4'h0, a_coarse}, 12'h0FF);
      wr(8'h10);
      tick(4);
      chk({4'h0, a_coarse}, 12'h010);
      ramp_en = 1'b1;
      ramp(1'b0, 8'h12, 2);
      ramp(1'b1, 8'h1A, 2);
      ramp(1'b1, 8'h13, 2);
      ramp_fast = 1'b0;
      wr(8'h40);
      tick(300);
      ramp(1'b0, 8'h14, 1);
      for (int p = 0; p < 2; p++) begin
         sysref_req = 1'b1;
         tick(1);
         sysref_req = 1'b0;
         tick(4);
         chk({11'h0, seen}, 12'h001);
         tick(1);
         chk({11'h0, seen}, 12'h000);
         tick(2);
      end
      stop_test();
   end
endmodule : sample_clock_delay_and_mark_bench
